// ===== sim/bcm_sync_src.sv
/*
 External sync clock source model.
 Assumes the bench sets the half period in ns.
*/
`timescale 1ns/10ps
module bcm_sync_src (
   input wire logic en_i,
   input wire logic [7:0] half_ns_i,
   output logic clk_o
);
   initial clk_o = 1'b0;
   // Stands low while off; odd start offset keeps edges off the system clock
   always begin
      if (en_i) begin
         #(half_ns_i) clk_o = ~clk_o;
      end else begin
         clk_o = 1'b0;
         @(posedge en_i);
         #1.3;
      end
   end
endmodule : bcm_sync_src

// ===== sim/bcm_top_assertions.sv
/*
 Port checker for bcm_top.
 Assumes the bind hands over the design's MEAS_CYCLES.
*/
`timescale 1ns/10ps
module bcm_top_assertions #(
   parameter int MEAS_CYCLES = 10000
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic adc_done_i,
   input wire logic [1:0] heavy_load_i,
   input wire logic meas_active_o,
   input wire logic meas_buck_o,
   input wire logic [1:0] buck_pwm_o,
   input wire logic pll_run_o,
   input wire logic clk_sel_ext_o,
   input wire logic spread_active_o,
   input wire logic [1:0] general_output_o,
   input wire logic [1:0] general_output_oe_o
);
   int run_cnt;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence sel_write;
      wr_i && addr_i == 8'h00;
   endsequence
   sequence adc_finish;
      meas_active_o && adc_done_i && !(wr_i && addr_i == 8'h00);
   endsequence

   // Run length; a relaunch starts the count over
   always_ff @(posedge clock_i) begin
      if (rst_i || !meas_active_o || (wr_i && addr_i == 8'h00)) begin
         run_cnt <= 0;
      end else begin
         run_cnt <= run_cnt + 1;
      end
   end

   a_launch_select: assert property (
      sel_write |=> meas_active_o && meas_buck_o == $past(wdata_i[0]))
      else $error("no launch on selected buck");
   a_meas_pwm: assert property (
      meas_active_o |-> buck_pwm_o[meas_buck_o])
      else $error("measured buck not in PWM");
   a_run_bound: assert property (
      run_cnt <= MEAS_CYCLES + 1)
      else $error("measurement too long");
   a_adc_end: assert property (
      adc_finish |=> !meas_active_o)
      else $error("run did not end on converter done");
   a_spread_rc: assert property (
      spread_active_o |-> !pll_run_o)
      else $error("spreading with PLL on");
   a_ext_pll: assert property (
      clk_sel_ext_o |-> pll_run_o)
      else $error("external clock without PLL");
   a_auto_pwm: assert property (
      heavy_load_i[0] [*3] |-> buck_pwm_o[0])
      else $error("heavy load not in PWM");
   a_second_general_output_pin: assert property (
      general_output_oe_o[1] |-> !pll_run_o)
      else $error("second output with detector on");
   a_od_low: assert property (
      !general_output_oe_o[0] |-> !general_output_o[0])
      else $error("released output not low");
endmodule : bcm_top_assertions

bind bcm_top bcm_top_assertions #(.MEAS_CYCLES(MEAS_CYCLES)) chk_u (
   .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .adc_done_i(adc_done_i), .heavy_load_i(heavy_load_i),
   .meas_active_o(meas_active_o), .meas_buck_o(meas_buck_o), .buck_pwm_o(buck_pwm_o),
   .pll_run_o(pll_run_o), .clk_sel_ext_o(clk_sel_ext_o),
   .spread_active_o(spread_active_o), .general_output_o(general_output_o),
   .general_output_oe_o(general_output_oe_o)
);

// ===== sim/testbench.sv
/*
 Self-checking bench for bcm_top.
 Assumes bcm_sync_src on the sync pin and a shortened MEAS_CYCLES.
*/
`timescale 1ns/10ps
module testbench;
   localparam int MC = 20;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic otp_load_i = 1'b0;
   logic [1:0] otp_fpwm_i = 2'h0;
   logic [1:0] buck_en_i = 2'h0;
   logic [1:0] heavy_load_i = 2'h0;
   logic [8:0] adc_code_i = 9'h000;
   logic adc_done_i = 1'b0;
   logic sync_en = 1'b0;
   logic [7:0] sync_half = 8'h32;
   logic sync_clock_in_i;
   logic [7:0] rdata_o;
   logic meas_active_o, meas_buck_o, pll_run_o, clk_sel_ext_o, spread_active_o, irq_o;
   logic [1:0] buck_pwm_o, general_output_o, general_output_oe_o;
   logic [7:0] rv;
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 32'h51a4943e;
   int cnt;
   int exp_code;
   logic [7:0] halves[$] = '{8'h32, 8'h41, 8'h4b, 8'h1e};
   logic [7:0] gpo_tab[$] = '{8'h01, 8'h02, 8'h03, 8'h14};

   always #2.5 clock_i = ~clock_i;

   bcm_top #(.MEAS_CYCLES(MC)) dut_u (
      .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .otp_load_i(otp_load_i),
      .otp_fpwm_i(otp_fpwm_i), .buck_en_i(buck_en_i), .heavy_load_i(heavy_load_i),
      .adc_code_i(adc_code_i), .adc_done_i(adc_done_i), .sync_clock_in_i(sync_clock_in_i),
      .meas_active_o(meas_active_o), .meas_buck_o(meas_buck_o), .buck_pwm_o(buck_pwm_o),
      .pll_run_o(pll_run_o), .clk_sel_ext_o(clk_sel_ext_o),
      .spread_active_o(spread_active_o), .irq_o(irq_o),
      .general_output_o(general_output_o), .general_output_oe_o(general_output_oe_o)
   );

   bcm_sync_src src_u (.en_i(sync_en), .half_ns_i(sync_half), .clk_o(sync_clock_in_i));

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      rv = rdata_o;
   endtask : rd

   // Window at 10 MHz nominal, h is the half period in ns
   function automatic logic win(input logic [7:0] h);
      return (14 * h * 10 <= 10000) && (22 * h * 10 >= 10000);
   endfunction : win

   function automatic logic [1:0] gpo_oe(input logic [7:0] d);
      return {d[4] & (~d[3] | ~d[2]), ~d[1] | ~d[0]};
   endfunction : gpo_oe

   function automatic logic [1:0] gpo_drv(input logic [7:0] d);
      return {d[4] & ~d[3] & d[2], ~d[1] & d[0]};
   endfunction : gpo_drv

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      #100000;
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
   end

   initial begin
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      tick(1);
      chk(general_output_oe_o, 2'h1);
      rd(8'h05);
      chk(rv, 8'h01);
      rd(8'h03);
      chk(rv, 8'h00);
      rd(8'h0f);
      chk(rv, 8'h00);
      $display("reset test done");
      // Nominal 10 MHz, PLL on, clock absent
      wr(8'h05, 8'h4a);
      @(posedge clock_i);
      otp_load_i <= 1'b1;
      otp_fpwm_i <= 2'h2;
      @(posedge clock_i);
      otp_load_i <= 1'b0;
      tick(2);
      rd(8'h03);
      chk(rv[1], 1'b1);
      rd(8'h08);
      chk(rv[1:0], 2'h2);
      wr(8'h03, 8'h02);
      rd(8'h03);
      chk(rv[1], 1'b0);
      @(posedge clock_i);
      buck_en_i <= 2'h1;
      tick(2);
      rd(8'h03);
      chk(rv[1], 1'b1);
      wr(8'h03, 8'h02);
      wr(8'h06, 8'h01);
      tick(1);
      chk(spread_active_o, 1'b0);
      wr(8'h05, 8'h0a);
      tick(1);
      chk(spread_active_o, 1'b1);
      chk(pll_run_o, 1'b0);
      wr(8'h05, 8'h4a);
      tick(1);
      chk(pll_run_o, 1'b1);
      $display("standby test done");
      sync_en <= 1'b1;
      foreach (halves[i]) begin
         sync_half <= halves[i];
         tick(300);
         chk(clk_sel_ext_o, win(halves[i]));
      end
      sync_en <= 1'b0;
      rd(8'h03);
      chk(rv[1], 1'b1);
      chk(irq_o, 1'b1);
      wr(8'h04, 8'h02);
      tick(1);
      chk(irq_o, 1'b0);
      wr(8'h03, 8'h02);
      wr(8'h04, 8'h00);
      $display("sync test done");
      adc_code_i <= 9'($random(seed));
      wr(8'h00, 8'h01);
      tick(0);
      chk(meas_active_o, 1'b1);
      chk(meas_buck_o, 1'b1);
      chk(buck_pwm_o[1], 1'b1);
      exp_code = adc_code_i;
      @(posedge clock_i);
      adc_done_i <= 1'b1;
      @(posedge clock_i);
      adc_done_i <= 1'b0;
      tick(2);
      chk(meas_active_o, 1'b0);
      chk(irq_o, 1'b1);
      rd(8'h01);
      chk(rv, exp_code[7:0]);
      rd(8'h02);
      chk(rv[0], exp_code[8]);
      wr(8'h04, 8'h01);
      tick(1);
      chk(irq_o, 1'b0);
      wr(8'h03, 8'h01);
      wr(8'h04, 8'h00);
      // Relaunch mid-run, then let the timer end it
      adc_code_i <= 9'($random(seed));
      wr(8'h00, 8'h00);
      tick(5);
      wr(8'h00, 8'h00);
      tick(0);
      chk(buck_pwm_o[0], 1'b1);
      chk(meas_buck_o, 1'b0);
      exp_code = adc_code_i;
      cnt = 0;
      while (meas_active_o === 1'b1 && cnt < MC + 10) begin
         tick(1);
         cnt++;
      end
      chk(cnt >= MC - 1 && cnt <= MC + 2, 1'b1);
      if (cnt >= MC + 10) begin
         end_sim();
      end
      rd(8'h01);
      chk(rv, exp_code[7:0]);
      rd(8'h09);
      chk(rv[6], 1'b0);
      $display("meas test done");
      for (int i = 0; i < 16; i++) begin
         @(posedge clock_i);
         heavy_load_i <= i[1:0];
         wr(8'h08, {6'h00, i[3:2]});
         tick(3);
         chk(buck_pwm_o, i[1:0] | i[3:2]);
      end
      $display("mode test done");
      foreach (gpo_tab[i]) begin
         wr(8'h07, gpo_tab[i]);
         tick(1);
         chk(general_output_oe_o, gpo_oe(gpo_tab[i]));
         chk(general_output_o & general_output_oe_o, gpo_drv(gpo_tab[i]));
         rd(8'h07);
         chk(rv, {3'h0, gpo_tab[i][4:0]});
      end
      chk(pll_run_o, 1'b0);
      $display("output test done");
      end_sim();
   end
endmodule : testbench

// ===== verilog/bcm_cfg.svh
/*
 Constants of the buck measurement and sync clock control block:
 register offsets, field positions, reset values and timing counts.
 Assumes an 8-bit register port and a 200 MHz system clock.
*/
`ifndef BCM_CFG_SVH
`define BCM_CFG_SVH

`define BCM_CLK_MHZ 200
`define BCM_MEAS_TIME_US 50
`define BCM_MEAS_CYCLES (`BCM_MEAS_TIME_US * `BCM_CLK_MHZ)
`define BCM_TIMER_W 14

`define BCM_ADDR_SEL 8'h00
`define BCM_ADDR_LOAD_LO 8'h01
`define BCM_ADDR_LOAD_HI 8'h02
`define BCM_ADDR_INT 8'h03
`define BCM_ADDR_MASK 8'h04
`define BCM_ADDR_PLL 8'h05
`define BCM_ADDR_CONFIG 8'h06
`define BCM_ADDR_GPO 8'h07
`define BCM_ADDR_BUCK 8'h08
`define BCM_ADDR_STAT 8'h09

`define BCM_BIT_MEAS 0
`define BCM_BIT_SYNC 1
`define BCM_BIT_PLL_EN 6
`define BCM_BIT_SPREAD 0
`define BCM_BIT_SECOND_GENERAL_OUTPUT_MODE 4

`define BCM_FREQ_RST 5'h01
`define BCM_FREQ_MIN 5'h01
`define BCM_FREQ_MAX 5'h18
`define BCM_FAST_NUM 20'h0000b
`define BCM_SLOW_NUM 20'h00007
`define BCM_RATIO_DEN 20'h007d0
`define BCM_PERIOD_MAX 9'h1ff
`define BCM_GOOD_PERIODS 2'h3

`endif

// ===== verilog/bcm_clk_detect.sv
/*
 External sync clock detector: measures the period of the pin clock in
 system cycles and flags it valid inside the -30%/+10% window.
 Assumes the pin is asynchronous to clock_i and at most 24 MHz.
*/
`timescale 1ns/10ps
`include "bcm_cfg.svh"

module bcm_clk_detect
   import bcm_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic sync_clock_in_i,
   input wire logic [4:0] freq_i,
   output logic valid_o
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   logic [8:0] period_reg;
   logic [1:0] good_reg;
   logic valid_reg;
   logic rise;
   logic [19:0] pf;
   logic ok;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= sync_clock_in_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~last_reg;
   assign pf = 20'(period_reg) * 20'(freq_i);
   // Period times frequency against the clock rate avoids a divider
   assign ok = (freq_i >= `BCM_FREQ_MIN) && (freq_i <= `BCM_FREQ_MAX)
      && (`BCM_FAST_NUM * pf >= `BCM_RATIO_DEN)
      && (`BCM_SLOW_NUM * pf <= `BCM_RATIO_DEN);

   always_ff @(posedge clock_i) begin
      if (rst_i || !enable_i || rise) begin
         period_reg <= 9'h001;
      end else if (period_reg != `BCM_PERIOD_MAX) begin
         period_reg <= period_reg + 9'h001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i || !enable_i || period_reg == `BCM_PERIOD_MAX) begin
         good_reg <= 2'h0;
      end else if (rise) begin
         if (!ok) begin
            good_reg <= 2'h0;
         end else if (good_reg != `BCM_GOOD_PERIODS) begin
            good_reg <= good_reg + 2'h1;
         end
      end
   end

   // Several good periods in a row filter a single lucky edge
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= enable_i && good_reg == `BCM_GOOD_PERIODS
            && period_reg != `BCM_PERIOD_MAX;
      end
   end

   assign valid_o = valid_reg;

endmodule : bcm_clk_detect

// ===== verilog/bcm_pkg.sv
/*
 Types of the buck measurement and sync clock control block.
 Assumes bcm_cfg.svh supplies all numeric constants.
*/
package bcm_pkg;

   typedef enum logic [2:0] {
      MEAS_IDLE = 3'b001,
      MEAS_RUN = 3'b010,
      MEAS_DONE = 3'b100
   } bcm_meas_state_type;

   typedef struct packed {
      logic buck;
      logic [8:0] code;
   } bcm_result_type;

   typedef struct packed {
      logic en;
      logic [4:0] freq;
   } bcm_pll_type;

   typedef struct packed {
      logic second_general_output_mode;
      logic [1:0] od;
      logic [1:0] level;
   } bcm_gpo_type;

endpackage : bcm_pkg

// ===== verilog/bcm_top.sv
/*
 Digital control of a dual buck device: load current measurement,
 sync clock selection and detection, spread spectrum and PWM/PFM choice.
 Assumes a register master on clock_i, analog inputs already timed to
 clock_i except the load comparators and the sync clock pin.
*/
// The register addresses and the address-and-strobe port were left to the implementer.
// Contract
// - A select bit chooses which buck core is measured.
// - Every write to the selection register starts a new measurement.
// - The measured buck is held in PWM during measurement.
// - A measurement finishes within 50 us of its launch.
// - Measurement completion sets the measurement-done flag.
// - The measurement-done mask bit suppresses its interrupt request.
// - Result bits 7..0 in low register, bit 8 in high register.
// - Result code is 20 mA per LSB, all ones is 10.22 A.
// - Spreading acts only while the PLL is disabled.
// - One spread enable bit spreads both buck cores.
// - Clock source and sync interrupt follow PLL enable and clock validity.
// - PLL on runs detector, auto-selects valid clock, interrupts on changes. The code runs it only once standby_reg is set and second-output mode is off.
// - The sync-clock mask bit suppresses its interrupt request.
// - A 5-bit field sets nominal sync frequency 1 to 24 MHz.
// - Sync clock valid only within -30% to +10% of nominal.
// - PLL on and no clock at standby entry sets the sync flag.
// - PLL on and no clock at standby-to-active sets the sync flag.
// - The sync clock pin can serve as second general output.
// - Each general output is selectable open-drain or push-pull.
// - Without forced PWM, PWM at heavy load, PFM at light load.
// - Forced PWM keeps PWM at every load.
// - Forced PWM defaults come from configuration bits.
`timescale 1ns/10ps
`include "bcm_cfg.svh"

module bcm_top
   import bcm_pkg::*;
#(
   parameter int MEAS_CYCLES = `BCM_MEAS_CYCLES
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic otp_load_i,
   input wire logic [1:0] otp_fpwm_i,
   input wire logic [1:0] buck_en_i,
   input wire logic [1:0] heavy_load_i,
   input wire logic [8:0] adc_code_i,
   input wire logic adc_done_i,
   input wire logic sync_clock_in_i,
   output logic meas_active_o,
   output logic meas_buck_o,
   output logic [1:0] buck_pwm_o,
   output logic pll_run_o,
   output logic clk_sel_ext_o,
   output logic spread_active_o,
   output logic irq_o,
   output logic [1:0] general_output_o,
   output logic [1:0] general_output_oe_o
);

   bcm_meas_state_type state_reg;
   bcm_result_type result_reg;
   bcm_pll_type pll_reg;
   bcm_gpo_type gpo_reg;
   logic [`BCM_TIMER_W-1:0] timer_reg;
   logic meas_sel_reg;
   logic meas_flag_reg;
   logic sync_flag_reg;
   logic meas_mask_reg;
   logic sync_mask_reg;
   logic spread_on_reg;
   logic [1:0] fpwm_reg;
   logic standby_reg;
   logic [1:0] buck_en_last_reg;
   logic valid_last_reg;
   logic [1:0] load_meta_reg;
   logic [1:0] load_sync_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic sel_write;
   logic finish;
   logic det_en;
   logic ext_valid;
   logic sync_set;
   logic meas_set;
   logic [1:0] drive_en;
   logic wr_int;
   logic wr_mask;
   logic wr_pll;
   logic wr_config;
   logic wr_gpo;
   logic wr_buck;
   logic clr_meas;
   logic clr_sync;
   logic sync_change;
   logic sync_boot;
   logic sync_start;
   logic meas_timeout;

   assign sel_write = wr_i && addr_i == `BCM_ADDR_SEL;
   assign wr_int = wr_i && addr_i == `BCM_ADDR_INT;
   assign wr_mask = wr_i && addr_i == `BCM_ADDR_MASK;
   assign wr_pll = wr_i && addr_i == `BCM_ADDR_PLL;
   assign wr_config = wr_i && addr_i == `BCM_ADDR_CONFIG;
   assign wr_gpo = wr_i && addr_i == `BCM_ADDR_GPO;
   assign wr_buck = wr_i && addr_i == `BCM_ADDR_BUCK;

   // Measurement sequence
   // Timeout bounds the sequence even if the converter never answers
   assign meas_timeout = timer_reg == `BCM_TIMER_W'(MEAS_CYCLES - 1);
   assign finish = state_reg == MEAS_RUN
      && (adc_done_i || meas_timeout);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_reg <= MEAS_IDLE;
      end else if (sel_write) begin
         state_reg <= MEAS_RUN;
      end else begin
         unique case (state_reg)
            MEAS_IDLE: begin
               state_reg <= MEAS_IDLE;
            end
            MEAS_RUN: begin
               if (finish) begin
                  state_reg <= MEAS_DONE;
               end
            end
            MEAS_DONE: begin
               state_reg <= MEAS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i || sel_write) begin
         timer_reg <= '0;
      end else if (state_reg == MEAS_RUN) begin
         timer_reg <= timer_reg + `BCM_TIMER_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meas_sel_reg <= 1'b0;
      end else if (sel_write) begin
         meas_sel_reg <= wdata_i[0];
      end
   end

   // Code is passed through unscaled at 20 mA per LSB
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         result_reg <= '0;
      end else if (finish) begin
         result_reg.buck <= meas_sel_reg;
         result_reg.code <= adc_code_i;
      end
   end

   assign meas_active_o = state_reg == MEAS_RUN;
   assign meas_buck_o = meas_sel_reg;
   assign meas_set = state_reg == MEAS_DONE;

   // Load comparators are analog, so synchronise them first
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         load_meta_reg <= 2'h0;
         load_sync_reg <= 2'h0;
      end else begin
         load_meta_reg <= heavy_load_i;
         load_sync_reg <= load_meta_reg;
      end
   end

   // Mode choice per core
   for (genvar b = 0; b < 2; b++) begin : g_mode
      assign buck_pwm_o[b] = fpwm_reg[b]
         || load_sync_reg[b]
         || (meas_active_o && meas_sel_reg == 1'(b));
   end

   // Device mode and sync clock
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         standby_reg <= 1'b0;
      end else if (otp_load_i) begin
         standby_reg <= 1'b1;
      end
   end

   assign det_en = pll_reg.en && standby_reg && !gpo_reg.second_general_output_mode;

   bcm_clk_detect u_detect (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .enable_i(det_en),
      .sync_clock_in_i(sync_clock_in_i),
      .freq_i(pll_reg.freq),
      .valid_o(ext_valid)
   );

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         valid_last_reg <= 1'b0;
      end else begin
         valid_last_reg <= ext_valid;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         buck_en_last_reg <= 2'h0;
      end else begin
         buck_en_last_reg <= buck_en_i;
      end
   end

   assign sync_change = det_en && ext_valid != valid_last_reg;
   assign sync_boot = otp_load_i && pll_reg.en && !ext_valid;
   assign sync_start = standby_reg && buck_en_last_reg == 2'h0 && buck_en_i != 2'h0
      && pll_reg.en && !ext_valid;
   assign sync_set = sync_change || sync_boot || sync_start;

   assign pll_run_o = det_en;
   // Valid lags the detector by a cycle, so gate it with the enable
   assign clk_sel_ext_o = det_en && ext_valid;
   assign spread_active_o = spread_on_reg && !pll_reg.en;

   assign clr_meas = wr_int && wdata_i[`BCM_BIT_MEAS];
   assign clr_sync = wr_int && wdata_i[`BCM_BIT_SYNC];

   // Flags: a set in the clearing cycle wins
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meas_flag_reg <= 1'b0;
      end else begin
         meas_flag_reg <= meas_set || (meas_flag_reg && !clr_meas);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sync_flag_reg <= 1'b0;
      end else begin
         sync_flag_reg <= sync_set || (sync_flag_reg && !clr_sync);
      end
   end

   assign irq_o = (meas_flag_reg && !meas_mask_reg)
      || (sync_flag_reg && !sync_mask_reg);

   // Control registers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meas_mask_reg <= 1'b0;
         sync_mask_reg <= 1'b0;
      end else if (wr_mask) begin
         meas_mask_reg <= wdata_i[`BCM_BIT_MEAS];
         sync_mask_reg <= wdata_i[`BCM_BIT_SYNC];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pll_reg.en <= 1'b0;
         pll_reg.freq <= `BCM_FREQ_RST;
      end else if (wr_pll) begin
         pll_reg.en <= wdata_i[`BCM_BIT_PLL_EN];
         pll_reg.freq <= wdata_i[4:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         spread_on_reg <= 1'b0;
      end else if (wr_config) begin
         spread_on_reg <= wdata_i[`BCM_BIT_SPREAD];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         gpo_reg <= '0;
      end else if (wr_gpo) begin
         gpo_reg.second_general_output_mode <= wdata_i[`BCM_BIT_SECOND_GENERAL_OUTPUT_MODE];
         gpo_reg.od <= {wdata_i[3], wdata_i[1]};
         gpo_reg.level <= {wdata_i[2], wdata_i[0]};
      end
   end

   // Defaults are loaded when configuration loading completes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fpwm_reg <= 2'h0;
      end else if (otp_load_i) begin
         fpwm_reg <= otp_fpwm_i;
      end else if (wr_buck) begin
         fpwm_reg <= wdata_i[1:0];
      end
   end

   // General outputs; the second one only while the pin is released
   assign drive_en = {gpo_reg.second_general_output_mode, 1'b1};

   for (genvar g = 0; g < 2; g++) begin : g_out
      assign general_output_o[g] = gpo_reg.od[g] ? 1'b0 : gpo_reg.level[g];
      assign general_output_oe_o[g] = drive_en[g]
         && (!gpo_reg.od[g] || !gpo_reg.level[g]);
   end

   // Read port
   always_comb begin
      rdata_next = 8'h00;
      unique case (addr_i)
         `BCM_ADDR_SEL: rdata_next = {7'h00, meas_sel_reg};
         `BCM_ADDR_LOAD_LO: rdata_next = result_reg.code[7:0];
         `BCM_ADDR_LOAD_HI: rdata_next = {7'h00, result_reg.code[8]};
         `BCM_ADDR_INT: rdata_next = {6'h00, sync_flag_reg, meas_flag_reg};
         `BCM_ADDR_MASK: rdata_next = {6'h00, sync_mask_reg, meas_mask_reg};
         `BCM_ADDR_PLL: rdata_next = {1'b0, pll_reg.en, 1'b0, pll_reg.freq};
         `BCM_ADDR_CONFIG: rdata_next = {7'h00, spread_on_reg};
         `BCM_ADDR_GPO: rdata_next = {3'h0, gpo_reg.second_general_output_mode, gpo_reg.od[1],
            gpo_reg.level[1], gpo_reg.od[0], gpo_reg.level[0]};
         `BCM_ADDR_BUCK: rdata_next = {6'h00, fpwm_reg};
         `BCM_ADDR_STAT: rdata_next = {1'b0, result_reg.buck, buck_pwm_o,
            clk_sel_ext_o, ext_valid, standby_reg, meas_active_o};
         default: rdata_next = 8'h00;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clock_i) begin
      if (rst_i || !rd_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

endmodule : bcm_top
